/* File: rtl/mcs_sequencer.sv */
// Contract
// - after power-up hold a startup phase with the reference level driven on the analog output before counting.
// - after startup enter the count-begin phase, start the cycle counter and start the analog circuits.
// - in the first cycle hold the judge idle from count 5 and begin combined compensation initial operation at 8.
// - at count 18 enter the measure phase and route the bridge differential to the analog output.
// - at count 51 enter idling whose length follows the sampling rate (5070, 482, 206 clocks); code idles to the detect start count: 5069, 461, 205.
// - at 10.24 kHz skip idling and run measurement cycles back to back.
// - at the detect start count of 51, 256, 512 or 5120 run pressure detection and restart the analog circuits.
// - 5 clocks after detect start run the judge, 8 clocks after it run compensation in normal mode.
// - in self-diagnosis at count 8 run only supply sensitivity compensation initial operation.
// - in self-diagnosis at count 18 force the bridge inputs to mid excitation and output a fixed value.
// - in self-diagnosis from count 51 run the check and idling for 49 clocks, then go back to normal.
// - after diagnosis restart analog at 100, judge idle at 105, compensation initial at 108, zero output at 118.
// - after the post-diagnosis measurement continue exactly as the normal cycle from idling onward.
`timescale 1ns/1ps
`default_nettype none
module mcs_sequencer
(
    input  wire logic              i_mclk,          // timer oscillator clock
    input  wire logic              i_rst_n,         // async reset, active low
    input  wire logic              i_settled,       // analog references settled
    input  wire logic [1:0]        i_rate_sel,      // sampling rate code
    input  wire logic              i_diag_en,       // self-diagnosis requested
    output logic                   o_ref_level_en,  // reference level on output
    output logic                   o_analog_start,  // analog circuit startup
    output logic                   o_judge_hold,    // judge kept inactive
    output logic                   o_judge_run,     // judge pos/neg decision
    output logic                   o_comp_initial,  // combined comp initial op
    output logic                   o_comp_normal,   // combined comp normal op
    output logic                   o_supply_comp,   // supply comp only, temp off
    output logic                   o_measure_out,   // bridge differential out
    output logic                   o_idle,          // idling
    output logic                   o_detect_run,    // pressure detection
    output logic                   o_bridge_mid,    // bridge forced to half
    output logic                   o_diag_check,    // diagnostic check running
    output mcs_pkg::mcs_state_e    o_state,         // current phase
    output logic [12:0]            o_count          // cycle count
);
    import mcs_pkg::*;

    mcs_state_e  state_q;
    mcs_state_e  state_d;
    logic        diag_q;
    logic        diag_d;
    logic [12:0] cnt;
    logic [12:0] det_cnt;
    logic        fast_rate;
    logic        clr;
    logic        post_q;
    logic        post_d;
    logic [12:0] post_offset;

    mcs_cnt_if cnt_bus ();

    // shared cycle counter
    mcs_cycle_counter u_counter
    (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .cnt_bus (cnt_bus.cnt)
    );

    assign cnt = cnt_bus.count;

    // detect start count per rate
    assign det_cnt   = (i_rate_sel == RATE_100HZ) ? DET_100HZ :
                       (i_rate_sel == RATE_1KHZ)  ? DET_1KHZ  :
                       (i_rate_sel == RATE_2KHZ)  ? DET_2KHZ  : DET_10K24HZ;
    assign fast_rate = (i_rate_sel == RATE_10K24HZ);

    // true one cycle before the counter reaches n
    function automatic logic hit(input logic [12:0] c, input logic [12:0] n);
        hit = (c == n - 13'h0001);
    endfunction

    // phase transitions decoded from the count
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_STARTUP:
                if (i_settled)
                    state_d = ST_COUNT_BEGIN;
            ST_COUNT_BEGIN:
                if (hit(cnt, CNT_JUDGE_IDLE))
                    state_d = ST_JUDGE_IDLE;
            ST_JUDGE_IDLE:
                if (hit(cnt, CNT_COMP_INIT + post_offset))
                    state_d = diag_q ? ST_DIAG_SUPPLY : ST_COMP_INIT;
            ST_COMP_INIT:
                if (hit(cnt, CNT_MEASURE + post_offset))
                    state_d = ST_MEASURE;
            ST_MEASURE:
                if (hit(cnt, CNT_IDLE + post_offset))
                    state_d = fast_rate ? ST_DETECT : ST_IDLE;
            ST_IDLE:
                if (hit(cnt, det_cnt))
                    state_d = ST_DETECT;
            ST_DETECT:
                if (hit(cnt, CNT_JUDGE_IDLE))
                    state_d = ST_JUDGE_ACTIVE;
            ST_JUDGE_ACTIVE:
                if (hit(cnt, CNT_COMP_INIT))
                    state_d = ST_COMP_NORMAL;
            ST_COMP_NORMAL:
                if (hit(cnt, CNT_MEASURE))
                    state_d = ST_MEASURE;
            ST_DIAG_SUPPLY:
                if (hit(cnt, CNT_MEASURE))
                    state_d = ST_DIAG_FORCED;
            ST_DIAG_FORCED:
                if (hit(cnt, CNT_IDLE))
                    state_d = ST_DIAG_CHECK;
            ST_DIAG_CHECK:
                if (hit(cnt, CNT_DIAG_RESTART))
                    state_d = ST_DIAG_RESTART;
            ST_DIAG_RESTART:
                if (hit(cnt, CNT_JUDGE_IDLE + post_offset))
                    state_d = ST_JUDGE_IDLE;
            default:
                state_d = ST_STARTUP;
        endcase
    end

    // counter restarts on entry to count-begin and detect only
    assign clr = (state_d != state_q) &&
                 ((state_d == ST_COUNT_BEGIN) || (state_d == ST_DETECT));
    assign cnt_bus.clear = clr;

    // diagnosis armed at count begin, dropped once the check ends
    assign diag_d = (state_d == ST_COUNT_BEGIN && state_q == ST_STARTUP) ? i_diag_en :
                    (state_d == ST_DIAG_RESTART) ? 1'b0 : diag_q;

    // counter is not cleared at the diag restart, so later phase counts sit 100 higher
    assign post_d      = (state_d == ST_DIAG_RESTART) ? 1'b1 :
                         ((state_d == ST_IDLE) || (state_d == ST_DETECT)) ? 1'b0 : post_q;
    assign post_offset = post_q ? CNT_DIAG_RESTART : 13'h0000;

    // phase and diagnosis flag registers
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= ST_STARTUP;
            diag_q  <= 1'b0;
            post_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            diag_q  <= diag_d;
            post_q  <= post_d;
        end
    end

    // phase outputs straight from the state flops
    assign o_ref_level_en = (state_q == ST_STARTUP);
    assign o_analog_start = (state_q == ST_COUNT_BEGIN) || (state_q == ST_DETECT) ||
                            (state_q == ST_DIAG_RESTART);
    assign o_judge_hold   = (state_q == ST_JUDGE_IDLE);
    assign o_judge_run    = (state_q == ST_JUDGE_ACTIVE);
    assign o_comp_initial = (state_q == ST_COMP_INIT);
    assign o_comp_normal  = (state_q == ST_COMP_NORMAL);
    assign o_supply_comp  = (state_q == ST_DIAG_SUPPLY);
    assign o_measure_out  = (state_q == ST_MEASURE);
    assign o_idle         = (state_q == ST_IDLE);
    assign o_detect_run   = (state_q == ST_DETECT);
    assign o_bridge_mid   = (state_q == ST_DIAG_FORCED);
    assign o_diag_check   = (state_q == ST_DIAG_CHECK);
    assign o_state        = state_q;
    assign o_count        = cnt;

    // checks on phase timing
    startup_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_ref_level_en && !i_settled) |=> o_ref_level_en)
        else $error("startup left before settling");

    begin_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(state_q == ST_COUNT_BEGIN) |-> (cnt == 13'h0000 && o_analog_start))
        else $error("count begin without cleared counter");

    judge_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_judge_hold) |-> (cnt == (post_q ? 13'h0069 : 13'h0005)) ##3 (o_comp_initial || o_supply_comp))
        else $error("judge idle or compensation start off count");

    measure_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ($rose(o_measure_out) && $past(o_comp_initial)) |-> (cnt == (post_q ? 13'h0076 : 13'h0012)))
        else $error("measure not entered at count 18");

    idle_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_idle) |-> (cnt == ($past(post_q) ? 13'h0097 : 13'h0033) && !fast_rate))
        else $error("idle entered off count or at fast rate");

    fast_no_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (fast_rate && o_measure_out && cnt == 13'h0032) |=> (o_detect_run && cnt == 13'h0000))
        else $error("fast rate did not chain cycles");

    detect_start_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ($rose(o_detect_run) && $past(o_idle)) |-> ($past(cnt) == det_cnt - 13'h0001 && o_analog_start))
        else $error("detect not at rate start count");

    judge_comp_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_detect_run) |-> o_detect_run[*5] ##1 o_judge_run[*3] ##1 o_comp_normal)
        else $error("judge or normal comp mistimed after detect");

    diag_supply_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_supply_comp) |-> (cnt == 13'h0008 && !o_comp_initial))
        else $error("supply comp off count 8");

    diag_forced_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_bridge_mid) |-> (cnt == 13'h0012 && $past(o_supply_comp)))
        else $error("bridge force off count 18");

    diag_check_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_diag_check) |-> (cnt == 13'h0033) ##48 (o_diag_check && cnt == 13'h0063)
        ##1 (state_q == ST_DIAG_RESTART))
        else $error("diagnostic check length wrong");

    post_diag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(state_q == ST_DIAG_RESTART) |-> (cnt == 13'h0064 && o_analog_start)
        ##5 (o_judge_hold && cnt == 13'h0069) ##3 (o_comp_initial && cnt == 13'h006C)
        ##10 (o_measure_out && cnt == 13'h0076))
        else $error("post diagnosis restart mistimed");

    post_diag_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ($rose(o_measure_out) && cnt == 13'h0076) |-> !diag_q ##33 (o_idle || o_detect_run))
        else $error("post diagnosis did not rejoin normal cycle");

endmodule
`default_nettype wire

/* File: rtl/mcs_pkg.sv */
package mcs_pkg;

    // counter width covers the longest detect start count
    localparam int          CNT_W            = 13;

    // phase entry counts, measured from the last counter clear
    localparam logic [12:0] CNT_JUDGE_IDLE   = 13'h0005;
    localparam logic [12:0] CNT_COMP_INIT    = 13'h0008;
    localparam logic [12:0] CNT_MEASURE      = 13'h0012;
    localparam logic [12:0] CNT_IDLE         = 13'h0033;
    localparam logic [12:0] CNT_DIAG_RESTART = 13'h0064;

    // detect start counts per sampling rate
    localparam logic [12:0] DET_100HZ        = 13'h1400;
    localparam logic [12:0] DET_1KHZ         = 13'h0200;
    localparam logic [12:0] DET_2KHZ         = 13'h0100;
    localparam logic [12:0] DET_10K24HZ      = 13'h0033;

    // nominal idle lengths per sampling rate
    localparam logic [12:0] IDLE_100HZ       = 13'h13CE;
    localparam logic [12:0] IDLE_1KHZ        = 13'h01E2;
    localparam logic [12:0] IDLE_2KHZ        = 13'h00CE;
    localparam logic [12:0] IDLE_10K24HZ     = 13'h0000;

    // sampling rate select codes
    localparam logic [1:0]  RATE_100HZ       = 2'h0;
    localparam logic [1:0]  RATE_1KHZ        = 2'h1;
    localparam logic [1:0]  RATE_2KHZ        = 2'h2;
    localparam logic [1:0]  RATE_10K24HZ     = 2'h3;

    // sequencer phases, one-hot
    typedef enum logic [12:0] {
        ST_STARTUP      = 13'h0001,
        ST_COUNT_BEGIN  = 13'h0002,
        ST_JUDGE_IDLE   = 13'h0004,
        ST_COMP_INIT    = 13'h0008,
        ST_MEASURE      = 13'h0010,
        ST_IDLE         = 13'h0020,
        ST_DETECT       = 13'h0040,
        ST_JUDGE_ACTIVE = 13'h0080,
        ST_COMP_NORMAL  = 13'h0100,
        ST_DIAG_SUPPLY  = 13'h0200,
        ST_DIAG_FORCED  = 13'h0400,
        ST_DIAG_CHECK   = 13'h0800,
        ST_DIAG_RESTART = 13'h1000
    } mcs_state_e;

endpackage

/* File: rtl/mcs_cnt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mcs_cnt_if;
    logic        clear;   // restart count at zero
    logic [12:0] count;   // current cycle count

    modport ctrl (output clear, input count);
    modport cnt  (input clear, output count);
endinterface
`default_nettype wire

/* File: rtl/mcs_cycle_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_cycle_counter
(
    input  wire logic  i_mclk,   // timer clock
    input  wire logic  i_rst_n,  // async reset, active low
    mcs_cnt_if.cnt     cnt_bus   // clear in, count out
);
    import mcs_pkg::*;

    logic [12:0] count_q;
    logic [12:0] count_d;

    // clear wins, otherwise count up and hold at the top
    assign count_d = cnt_bus.clear ? 13'h0000 :
                     (&count_q)    ? count_q  : count_q + 13'h0001;

    // single cycle counter register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count_q <= 13'h0000;
        else
            count_q <= count_d;
    end

    assign cnt_bus.count = count_q;
endmodule
`default_nettype wire

/* File: test/mcs_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_front_model
#(
    parameter int SETTLE_CYCLES = 3  // analog settling time in clocks
)
(
    input  wire logic i_mclk,          // timer clock
    input  wire logic i_rst_n,         // async reset, active low
    input  wire logic i_ref_level_en,  // sequencer holds startup
    output logic      o_settled        // references have come up
);
    logic [3:0] settle_q;

    // references settle only while the startup phase is held
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            settle_q <= 4'h0;
        else if (i_ref_level_en && settle_q != 4'(SETTLE_CYCLES))
            settle_q <= settle_q + 4'h1;
    end

    assign o_settled = (settle_q == 4'(SETTLE_CYCLES));
endmodule
`default_nettype wire

/* File: test/measurement_cycle_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value %s expected %0d seen %0d", nm, exp, got); end end
module measurement_cycle_sequencer_bench;
    import mcs_pkg::*;
    logic        i_mclk, i_rst_n, i_settled, i_diag_en;
    logic [1:0]  i_rate_sel;
    logic [11:0] obs;
    mcs_state_e  o_state;
    logic [12:0] o_count;
    int          num_errors, total_checks, cycles, r;
    int          last[12];
    typedef struct { logic [1:0] rate; int period; int idle_at; } mcs_row_s;
    mcs_row_s    rows[4] = '{'{RATE_10K24HZ, 51, -1}, '{RATE_2KHZ, 256, 51},
                             '{RATE_1KHZ, 512, 51}, '{RATE_100HZ, 5120, 51}};

    mcs_sequencer i_mcs_sequencer (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_settled(i_settled),
        .i_rate_sel(i_rate_sel), .i_diag_en(i_diag_en), .o_ref_level_en(obs[0]),
        .o_analog_start(obs[1]), .o_judge_hold(obs[2]), .o_judge_run(obs[3]),
        .o_comp_initial(obs[4]), .o_comp_normal(obs[5]), .o_supply_comp(obs[6]),
        .o_measure_out(obs[7]), .o_idle(obs[8]), .o_detect_run(obs[9]),
        .o_bridge_mid(obs[10]), .o_diag_check(obs[11]), .o_state(o_state), .o_count(o_count));
    mcs_front_model i_mcs_front_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_ref_level_en(obs[0]), .o_settled(i_settled));

    // clock and hang guard
    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            $display("wrong value timeout expected 0 seen 1");
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reset with a chosen diagnosis request, startup held until settled
    task automatic do_reset(input logic diag);
        @(posedge i_mclk);
        i_rst_n   <= 1'b0;
        i_diag_en <= diag;
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("reset state", ST_STARTUP, o_state)
        `CHK("reset count", 13'h0000, o_count)
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(negedge i_mclk);
        `CHK("startup ref level", 1'b1, obs[0])
    endtask

    // wait for an output to rise, bounded
    task automatic wait_rise(input int b);
        int   k;
        logic p;
        p = obs[b];
        for (k = 0; k < 12000; k++)
        begin
            @(negedge i_mclk);
            if (obs[b] === 1'b1 && p !== 1'b1)
                return;
            p = obs[b];
        end
        num_errors++;
        $display("wrong value rise expected 1 seen 0");
    endtask

    // record the last rising index of every phase output over n cycles
    task automatic trace(input int n);
        int          i;
        int          b;
        logic [11:0] prev;
        prev = 12'h000;
        for (b = 0; b < 12; b++)
            last[b] = -1;
        for (i = 0; i < n; i++)
        begin
            if (i > 0)
                @(negedge i_mclk);
            for (b = 0; b < 12; b++)
                if (obs[b] === 1'b1 && prev[b] !== 1'b1)
                    last[b] = i;
            prev = obs;
        end
    endtask

    initial
    begin
        num_errors   = 0;
        total_checks = 0;
        cycles       = 0;
        i_rst_n      = 1'b0;
        i_diag_en    = 1'b0;
        i_rate_sel   = RATE_2KHZ;
        do_reset(1'b0);
        // first normal cycle from count start
        wait_rise(1);
        `CHK("begin count", 13'h0000, o_count)
        `CHK("begin state", ST_COUNT_BEGIN, o_state)
        trace(52);
        `CHK("judge hold", 5, last[2])
        `CHK("comp initial", 8, last[4])
        `CHK("measure", 18, last[7])
        `CHK("idle", 51, last[8])
        $display("test first_cycle done");
        // steady cycles for every sampling rate
        for (r = 0; r < 4; r++)
        begin
            // change rate just after a detect start, never inside idling
            wait_rise(9);
            @(posedge i_mclk);
            i_rate_sel <= rows[r].rate;
            wait_rise(9);
            trace(rows[r].period + 1);
            `CHK("judge run", 5, last[3])
            `CHK("comp normal", 8, last[5])
            `CHK("measure", 18, last[7])
            `CHK("idle", rows[r].idle_at, last[8])
            `CHK("detect period", rows[r].period, last[9])
            $display("test rate %0d done", r);
        end
        // self-diagnosis pass after a mid-run reset
        do_reset(1'b1);
        wait_rise(1);
        trace(160);
        `CHK("supply comp", 8, last[6])
        `CHK("bridge mid", 18, last[10])
        `CHK("diag check", 51, last[11])
        `CHK("restart", 100, last[1])
        `CHK("judge hold", 105, last[2])
        `CHK("comp initial", 108, last[4])
        `CHK("measure", 118, last[7])
        `CHK("idle", 151, last[8])
        wait_rise(9);
        `CHK("detect after diag", ST_DETECT, o_state)
        $display("test self_diag done");
        conclude();
    end
endmodule
`default_nettype wire
